// *** hdl/fplk_top.sv ***
// fault, peak, reset-count and run-time log keeper
//
// What this block does
// - keep a logged peak for every rail
// - larger value starts 30 s window, no write
// - window end commits only the largest value
// - store many fault entries, host reads them
// - fault entry: rail, type, time, voltage
// - count resets; host request clears count
// - brownout mode: flash only at power-down
// - run-time clock kept or zeroed per mode
// - host may write the run-time clock
// - supply below 2.9 V means brownout
// - brownout copies whole ram image to flash
// - brownout mode: no flash writes otherwise
// - brownout mode is an optional host setting
`timescale 1ns/1ps
`include "fplk_defs.svh"
module fplk_top
    import fplk_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `FPLK_CYC_PER_MS,
    parameter int unsigned WINDOW_MS = `FPLK_WINDOW_MS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic meas_valid,
    input wire fplk_meas_s meas,
    input wire logic fault_valid,
    input wire fplk_fault_s fault,
    output logic fault_ready,
    input wire logic bo_mode_en,
    input wire logic vcc_below_2v9,
    input wire logic [`FPLK_DW-1:0] nv_reset_count,
    input wire logic [`FPLK_DW-1:0] nv_rtc,
    input wire logic host_clr_count,
    input wire logic host_rtc_wr,
    input wire logic [`FPLK_DW-1:0] host_rtc_value,
    input wire logic host_rd_req,
    input wire logic [`FPLK_AW-1:0] host_rd_addr,
    output logic host_rd_ready,
    output logic host_rd_valid,
    output logic [`FPLK_DW-1:0] host_rd_data,
    output logic flash_req,
    output fplk_word_s flash_word,
    input wire logic flash_ack,
    output logic window_active,
    output logic bo_done
);
    localparam int unsigned NR = `FPLK_RAILS;

    // lowest set bit of a rail mask
    function automatic logic [3:0] first_set(input logic [NR-1:0] m);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NR - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // word address of fault entry n (two words each)
    function automatic logic [`FPLK_AW-1:0] flt_addr(input logic [3:0] n);
        return 6'(`FPLK_FLT_BASE + {1'b0, n, 1'b0});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    fplk_state_e state_ff, nxt_state;
    fplk_word_s wr_ff, nxt_wr;          // word being written
    logic [1:0] phase_ff, nxt_phase;    // fault entry word phase
    logic dump_ff, nxt_dump;            // brownout copy under way
    logic dump_rd_ff, nxt_dump_rd;      // copy reached the read loop
    logic [`FPLK_AW-1:0] daddr_ff, nxt_daddr;
    logic [31:0] div_ff;                // ms divider
    logic [31:0] win_ms_ff, nxt_win_ms; // window age in ms
    logic win_active_ff, nxt_win_active;
    logic [NR-1:0] dirty_ff, nxt_dirty; // rails with pending candidate
    logic [NR-1:0] mask_ff, nxt_mask;   // rails waiting for commit
    logic [`FPLK_VW-1:0] logged_ff [NR];
    logic [`FPLK_VW-1:0] pending_ff [NR];
    logic [31:0] cnt_ff;                // device reset count
    logic cnt_dirty_ff;
    logic [31:0] rtc_ff;                // run-time clock, ms
    logic [31:0] since_ff;              // ms since this reset
    logic flt_pend_ff;
    fplk_fault_s flt_ff;
    logic [31:0] flt_time_ff;
    logic [3:0] nflt_ff;
    logic bo_s1_ff, bo_s2_ff;           // brownout pin synchroniser
    logic host_rd_valid_ff;
    logic pick, cnt_take, flt_take, flt_drop;
    logic [`FPLK_DW-1:0] mem_rd_data;

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire ms_tick = (div_ff == 32'(CYC_PER_MS - 1));
    wire expire = win_active_ff && ms_tick &&
                  (win_ms_ff == 32'(WINDOW_MS - 1));
    wire live = (state_ff != ST_INIT) && (state_ff != ST_DONE);
    wire rail_ok = (meas.rail < 4'(NR));
    wire [3:0] m_idx = rail_ok ? meas.rail : 4'h0;
    wire m_held = dirty_ff[m_idx] | mask_ff[m_idx];
    wire [`FPLK_VW-1:0] ref_v = m_held ? pending_ff[m_idx] :
                                         logged_ff[m_idx];
    wire m_up = meas_valid && rail_ok && live && (meas.volt > ref_v);
    wire [NR-1:0] m_bit = m_up ? NR'(1 << m_idx) : '0;
    wire [3:0] pick_idx = first_set(mask_ff);
    wire [NR-1:0] pick_bit = pick ? NR'(1 << pick_idx) : '0;
    wire bo_lvl = bo_s2_ff;
    wire flash_need = dump_ff || !bo_mode_en;
    wire wr_done = !flash_need || flash_ack;
    wire flt_acc = fault_valid && fault_ready;
    wire host_acc = host_rd_req && host_rd_ready;
    wire dump_read = (state_ff == ST_DUMP_RD);

    // peak candidate and window bookkeeping
    always_comb begin
        nxt_dirty = (expire ? '0 : dirty_ff) | m_bit;
        nxt_mask = (mask_ff & ~pick_bit) | (expire ? dirty_ff : '0);
        nxt_win_active = m_up ? 1'b1 : (expire ? 1'b0 : win_active_ff);
        nxt_win_ms = win_ms_ff;
        if (m_up && (!win_active_ff || expire)) begin
            nxt_win_ms = '0;
        end else if (win_active_ff && ms_tick) begin
            nxt_win_ms = win_ms_ff + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: picks the next word to store, then writes it
    always_comb begin
        nxt_state = state_ff;
        nxt_wr = wr_ff;
        nxt_phase = phase_ff;
        nxt_dump = dump_ff;
        nxt_dump_rd = dump_rd_ff;
        nxt_daddr = daddr_ff;
        pick = 1'b0;
        cnt_take = 1'b0;
        flt_take = 1'b0;
        flt_drop = 1'b0;
        case (state_ff)
            ST_INIT: begin
                nxt_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (bo_lvl && bo_mode_en) begin
                    // power is going: save clock, then copy image
                    nxt_wr = '{addr: `FPLK_RTC_ADDR, data: rtc_ff};
                    nxt_dump = 1'b1;
                    nxt_state = ST_WR;
                end else if (|mask_ff) begin
                    // commit one rail's window maximum
                    pick = 1'b1;
                    nxt_wr = '{addr: 6'(pick_idx),
                               data: {20'h00000, pending_ff[pick_idx]}};
                    nxt_state = ST_WR;
                end else if (flt_pend_ff &&
                             nflt_ff == 4'(`FPLK_MAX_FAULTS)) begin
                    // log full: report dropped
                    flt_drop = 1'b1;
                end else if (flt_pend_ff) begin
                    // first word: valid, rail, type, voltage
                    nxt_wr = '{addr: flt_addr(nflt_ff),
                               data: {1'b1, 7'h00, flt_ff.rail,
                                      flt_ff.ftype, 4'h0,
                                      flt_ff.volt}};
                    nxt_phase = 2'h1;
                    nxt_state = ST_WR;
                end else if (cnt_dirty_ff) begin
                    cnt_take = 1'b1;
                    nxt_wr = '{addr: `FPLK_CNT_ADDR, data: cnt_ff};
                    nxt_state = ST_WR;
                end
            end
            ST_WR: begin
                if (wr_done) begin
                    if (dump_ff) begin
                        // walk the whole image into flash
                        if (!dump_rd_ff) begin
                            nxt_dump_rd = 1'b1;
                            nxt_daddr = '0;
                            nxt_state = ST_DUMP_RD;
                        end else if (daddr_ff == `FPLK_LAST_ADDR) begin
                            nxt_state = ST_DONE;
                        end else begin
                            nxt_daddr = daddr_ff + 6'h01;
                            nxt_state = ST_DUMP_RD;
                        end
                    end else if (phase_ff == 2'h1) begin
                        // second word: time since reset
                        nxt_wr = '{addr: wr_ff.addr + 6'h01,
                                   data: flt_time_ff};
                        nxt_phase = 2'h2;
                    end else if (phase_ff == 2'h2) begin
                        nxt_phase = 2'h0;
                        flt_take = 1'b1;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_DUMP_RD: begin
                nxt_state = ST_DUMP_LD;
            end
            ST_DUMP_LD: begin
                nxt_wr = '{addr: daddr_ff, data: mem_rd_data};
                nxt_state = ST_WR;
            end
            ST_DONE: begin
                nxt_state = ST_DONE;
            end
            default: begin
                nxt_state = ST_INIT;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer and window registers
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= ST_INIT;
            wr_ff <= '0;
            phase_ff <= 2'h0;
            dump_ff <= 1'b0;
            dump_rd_ff <= 1'b0;
            daddr_ff <= '0;
            win_ms_ff <= '0;
            win_active_ff <= 1'b0;
            dirty_ff <= '0;
            mask_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            wr_ff <= nxt_wr;
            phase_ff <= nxt_phase;
            dump_ff <= nxt_dump;
            dump_rd_ff <= nxt_dump_rd;
            daddr_ff <= nxt_daddr;
            win_ms_ff <= nxt_win_ms;
            win_active_ff <= nxt_win_active;
            dirty_ff <= nxt_dirty;
            mask_ff <= nxt_mask;
        end
    end

    // per-rail logged peak and window candidate
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < NR; i++) begin
                logged_ff[i] <= '0;
                pending_ff[i] <= '0;
            end
        end else begin
            if (m_up) begin
                pending_ff[m_idx] <= meas.volt;
            end
            if (pick) begin
                logged_ff[pick_idx] <= pending_ff[pick_idx];
            end
        end
    end

    // ms divider, run-time clock and time since reset
    always_ff @(posedge clock) begin
        if (reset) begin
            div_ff <= '0;
            since_ff <= '0;
            rtc_ff <= '0;
        end else begin
            div_ff <= ms_tick ? '0 : div_ff + 32'h1;
            since_ff <= since_ff + (ms_tick ? 32'h1 : 32'h0);
            if (state_ff == ST_INIT) begin
                rtc_ff <= bo_mode_en ? nv_rtc : '0;
            end else if (host_rtc_wr) begin
                rtc_ff <= host_rtc_value;
            end else if (ms_tick) begin
                rtc_ff <= rtc_ff + 32'h1;
            end
        end
    end

    // reset count: loaded plus one, host clear wins over a write
    always_ff @(posedge clock) begin
        if (reset) begin
            cnt_ff <= '0;
            cnt_dirty_ff <= 1'b0;
        end else if (state_ff == ST_INIT) begin
            cnt_ff <= nv_reset_count + 32'h1;
            cnt_dirty_ff <= 1'b1;
        end else if (host_clr_count) begin
            cnt_ff <= '0;
            cnt_dirty_ff <= 1'b1;
        end else if (cnt_take) begin
            cnt_dirty_ff <= 1'b0;
        end
    end

    // fault holding register and entry count
    always_ff @(posedge clock) begin
        if (reset) begin
            flt_pend_ff <= 1'b0;
            flt_ff <= '0;
            flt_time_ff <= '0;
            nflt_ff <= 4'h0;
        end else begin
            if (flt_acc) begin
                flt_pend_ff <= 1'b1;
                flt_ff <= fault;
                flt_time_ff <= since_ff;
            end else if (flt_take || flt_drop) begin
                flt_pend_ff <= 1'b0;
            end
            if (flt_take) begin
                nflt_ff <= nflt_ff + 4'h1;
            end
        end
    end

    // brownout comparator pin and host read valid
    always_ff @(posedge clock) begin
        if (reset) begin
            bo_s1_ff <= 1'b0;
            bo_s2_ff <= 1'b0;
            host_rd_valid_ff <= 1'b0;
        end else begin
            bo_s1_ff <= vcc_below_2v9;
            bo_s2_ff <= bo_s1_ff;
            host_rd_valid_ff <= host_acc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // log image ram, copy has the read port while dumping
    fplk_mem u_mem (
        .clock(clock),
        .reset(reset),
        .wr_en(state_ff == ST_WR),
        .wr_addr(wr_ff.addr),
        .wr_data(wr_ff.data),
        .rd_en(dump_read || host_acc),
        .rd_addr(dump_ff ? daddr_ff : host_rd_addr),
        .rd_data(mem_rd_data)
    );

    // outputs
    assign flash_req = (state_ff == ST_WR) && flash_need;
    assign flash_word = wr_ff;
    assign fault_ready = !flt_pend_ff;
    assign host_rd_ready = !dump_ff;
    assign host_rd_valid = host_rd_valid_ff;
    assign host_rd_data = mem_rd_data;
    assign window_active = win_active_ff;
    assign bo_done = (state_ff == ST_DONE);

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    flash_quiet_a: assert property (
        bo_mode_en && !dump_ff |-> !flash_req)
        else $error("flash write in brownout mode before power-down");
    window_start_a: assert property (
        m_up && !win_active_ff |=> win_active_ff && win_ms_ff == 0)
        else $error("larger value did not start the window");
    window_keep_a: assert property (
        m_up && win_active_ff && !expire && ms_tick
        |=> win_ms_ff == $past(win_ms_ff) + 1)
        else $error("window restarted by a later peak");
    commit_max_a: assert property (
        pick |=> wr_ff.data[`FPLK_VW-1:0] == $past(pending_ff[pick_idx])
                 && logged_ff[$past(pick_idx)] == wr_ff.data[`FPLK_VW-1:0])
        else $error("commit did not store the window maximum");
    count_clear_a: assert property (
        host_clr_count && state_ff != ST_INIT |=> cnt_ff == 0 ##0
        cnt_dirty_ff)
        else $error("reset count not cleared");
    rtc_write_a: assert property (
        host_rtc_wr && state_ff != ST_INIT
        |=> rtc_ff == $past(host_rtc_value))
        else $error("host clock write lost");
    rtc_zero_a: assert property (
        state_ff == ST_INIT && !bo_mode_en |=> rtc_ff == 0)
        else $error("clock not zeroed without brownout mode");
    dump_start_a: assert property (
        state_ff == ST_IDLE && bo_lvl && bo_mode_en
        |=> flash_req && flash_word.addr == `FPLK_RTC_ADDR)
        else $error("brownout did not start the copy");
    fault_take_a: assert property (
        flt_acc |=> flt_pend_ff && flt_ff == $past(fault))
        else $error("fault report not held");

    commit_c: cover property (expire ##[1:20] pick);
    fault_c: cover property (flt_acc ##[1:40] flt_take);
    dump_c: cover property (dump_ff ##[1:1000] bo_done);
endmodule

// *** include/fplk_defs.svh ***
// constants for the fault and peak log keeper
`ifndef FPLK_DEFS_SVH
`define FPLK_DEFS_SVH
// log geometry
`define FPLK_RAILS 12
`define FPLK_MAX_FAULTS 12
`define FPLK_AW 6
`define FPLK_DW 32
`define FPLK_VW 12
`define FPLK_DEPTH 64
// word map of the log image (peaks sit at word = rail number)
`define FPLK_FLT_BASE 6'h10
`define FPLK_CNT_ADDR 6'h30
`define FPLK_RTC_ADDR 6'h31
`define FPLK_LAST_ADDR 6'h3f
// timing
`define FPLK_CLK_HZ 100000000
`define FPLK_MS_PER_S 1000
`define FPLK_CYC_PER_MS (`FPLK_CLK_HZ / `FPLK_MS_PER_S)
`define FPLK_WINDOW_S 30
`define FPLK_WINDOW_MS (`FPLK_WINDOW_S * `FPLK_MS_PER_S)
// supply level below which the external comparator flags brownout
`define FPLK_BROWNOUT_MV 2900
`endif

// *** include/fplk_pkg.sv ***
// types shared by the log keeper files
package fplk_pkg;
`include "fplk_defs.svh"

    // sequencer states
    typedef enum logic [2:0] {
        ST_INIT,
        ST_IDLE,
        ST_WR,
        ST_DUMP_RD,
        ST_DUMP_LD,
        ST_DONE
    } fplk_state_e;

    // one rail measurement
    typedef struct packed {
        logic [3:0] rail;
        logic [`FPLK_VW-1:0] volt;
    } fplk_meas_s;

    // one fault report
    typedef struct packed {
        logic [3:0] rail;
        logic [3:0] ftype;
        logic [`FPLK_VW-1:0] volt;
    } fplk_fault_s;

    // one word of the log image with its address
    typedef struct packed {
        logic [`FPLK_AW-1:0] addr;
        logic [`FPLK_DW-1:0] data;
    } fplk_word_s;
endpackage

// *** hdl/fplk_mem.sv ***
// log image ram with registered read data
`timescale 1ns/1ps
`include "fplk_defs.svh"
module fplk_mem (
    input wire logic clock,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [`FPLK_AW-1:0] wr_addr,
    input wire logic [`FPLK_DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [`FPLK_AW-1:0] rd_addr,
    output logic [`FPLK_DW-1:0] rd_data
);
    // storage array, no reset on contents
    logic [`FPLK_DW-1:0] mem_ff [`FPLK_DEPTH];
    // read register
    logic [`FPLK_DW-1:0] rd_data_ff;

    ////////////////////////////////////////////////////////////////////////
    // write port
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the request
    always_ff @(posedge clock) begin
        if (reset) begin
            rd_data_ff <= '0;
        end else if (rd_en) begin
            rd_data_ff <= mem_ff[rd_addr];
        end
    end

    assign rd_data = rd_data_ff;
endmodule

// *** sim/fplk_flash_model.sv ***
// flash array model that takes log words with an adjustable stall
`timescale 1ns/1ps
module fplk_flash_model
    import fplk_pkg::*;
(
    input wire logic clock,
    input wire logic flash_req,
    input wire fplk_word_s flash_word,
    input wire logic [3:0] ack_wait,
    output logic flash_ack
);
    fplk_word_s log_q[$]; // accepted words in arrival order
    logic [3:0] stall_ff; // cycles the open request has waited
    initial flash_ack = 1'b0;
    initial stall_ff = 4'h0;
    ////////////////////////////////////////////////////////////////////
    // ack stands one cycle once the stall runs out; word kept on ack
    always @(posedge clock) begin
        if (flash_req && flash_ack) begin
            log_q.push_back(flash_word);
        end
        flash_ack <= flash_req && !flash_ack && (stall_ff >= ack_wait);
        stall_ff <= (flash_req && !flash_ack) ? stall_ff + 4'h1 : 4'h0;
    end
endmodule

// *** sim/fplk_top_bench.sv ***
// self-checking bench for the fault and peak log keeper
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
end
module fplk_top_bench
    import fplk_pkg::*;
;
    int num_errors = 0; // mismatches
    int checks = 0; // comparisons made
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic meas_valid = 1'b0;
    fplk_meas_s meas = '0;
    logic fault_valid = 1'b0;
    fplk_fault_s fault = '0;
    logic fault_ready, host_rd_ready, host_rd_valid, flash_req, flash_ack;
    logic bo_mode_en = 1'b0;
    logic vcc_below_2v9 = 1'b0;
    logic [31:0] nv_reset_count = 32'h5;
    logic [31:0] nv_rtc = 32'h500;
    logic host_clr_count = 1'b0;
    logic host_rtc_wr = 1'b0;
    logic [31:0] host_rtc_value = 32'h0;
    logic host_rd_req = 1'b0;
    logic [5:0] host_rd_addr = 6'h0;
    logic [31:0] host_rd_data;
    logic window_active, bo_done;
    fplk_word_s flash_word;
    logic [3:0] ack_wait = 4'h0; // flash stall per word
    int n; // cycle counter of a scenario
    ////////////////////////////////////////////////////////////////////
    // short counts: 4 cycles per ms, 3 ms window
    fplk_top #(.CYC_PER_MS(4), .WINDOW_MS(3)) u_dut (
        .clock(clock), .reset(reset), .meas_valid(meas_valid),
        .meas(meas), .fault_valid(fault_valid), .fault(fault),
        .fault_ready(fault_ready), .bo_mode_en(bo_mode_en),
        .vcc_below_2v9(vcc_below_2v9), .nv_reset_count(nv_reset_count),
        .nv_rtc(nv_rtc), .host_clr_count(host_clr_count),
        .host_rtc_wr(host_rtc_wr), .host_rtc_value(host_rtc_value),
        .host_rd_req(host_rd_req), .host_rd_addr(host_rd_addr),
        .host_rd_ready(host_rd_ready), .host_rd_valid(host_rd_valid),
        .host_rd_data(host_rd_data), .flash_req(flash_req),
        .flash_word(flash_word), .flash_ack(flash_ack),
        .window_active(window_active), .bo_done(bo_done)
    );
    fplk_flash_model u_flash (
        .clock(clock), .flash_req(flash_req), .flash_word(flash_word),
        .ack_wait(ack_wait), .flash_ack(flash_ack)
    );
    initial begin
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////
    // inputs change one ns after the rising edge
    task tick();
        @(posedge clock);
        #1;
    endtask
    task give_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task do_reset(input logic bo);
        reset = 1'b1;
        vcc_below_2v9 = 1'b0;
        bo_mode_en = bo;
        repeat (6) tick();
        u_flash.log_q.delete();
        reset = 1'b0;
    endtask
    // wait for a number of flash words, bounded
    task wait_q(input int cnt);
        for (n = 0; n < 300 && u_flash.log_q.size() < cnt; n++) tick();
        `CHK("flash words", cnt, u_flash.log_q.size())
    endtask
    task wait_done();
        for (n = 0; n < 3000 && bo_done !== 1'b1; n++) tick();
        `CHK("copy done", 1'b1, bo_done)
    endtask
    task host_read(input logic [5:0] a, input logic [31:0] exp);
        host_rd_addr = a;
        host_rd_req = 1'b1;
        for (n = 0; n < 50 && host_rd_ready !== 1'b1; n++) tick();
        tick();
        host_rd_req = 1'b0;
        for (n = 0; n < 3 && host_rd_valid !== 1'b1; n++) tick();
        `CHK("read valid", 1'b1, host_rd_valid)
        `CHK("read data", exp, host_rd_data)
    endtask
    task send_fault(input logic [3:0] r, input logic [3:0] t,
                    input logic [11:0] v);
        fault = '{rail: r, ftype: t, volt: v};
        fault_valid = 1'b1;
        for (n = 0; n < 50 && fault_ready !== 1'b1; n++) tick();
        tick();
        fault_valid = 1'b0;
        `CHK("fault busy", 1'b0, fault_ready)
    endtask
    ////////////////////////////////////////////////////////////////////
    // reset count logged after reset, then cleared by the host
    task t_count();
        do_reset(1'b0);
        wait_q(1);
        `CHK("count addr", 6'h30, u_flash.log_q[0].addr)
        `CHK("count data", 32'h6, u_flash.log_q[0].data)
        host_clr_count = 1'b1;
        tick();
        host_clr_count = 1'b0;
        wait_q(2);
        `CHK("cleared count", 32'h0, u_flash.log_q[1].data)
        host_read(6'h30, 32'h0);
    endtask
    // one window, larger value inside it, only the maximum committed
    task t_peak();
        do_reset(1'b0);
        wait_q(1);
        meas = '{rail: 4'h3, volt: 12'h100};
        meas_valid = 1'b1;
        tick();
        meas_valid = 1'b0;
        `CHK("window open", 1'b1, window_active)
        repeat (5) tick();
        meas = '{rail: 4'h3, volt: 12'h200};
        meas_valid = 1'b1;
        tick();
        meas = '{rail: 4'h3, volt: 12'h150};
        tick();
        meas_valid = 1'b0;
        `CHK("no write in window", 1, u_flash.log_q.size())
        for (n = 8; n < 40 && window_active === 1'b1; n++) tick();
        `CHK("window length", 1'b1, n >= 9 && n <= 14)
        wait_q(2);
        `CHK("peak addr", 6'h3, u_flash.log_q[1].addr)
        `CHK("peak max", 32'h200, u_flash.log_q[1].data)
        host_read(6'h3, 32'h200);
    endtask
    // two fault entries, four items checked on the first, address on the second
    task t_fault();
        do_reset(1'b0);
        wait_q(1);
        send_fault(4'h5, 4'h2, 12'habc);
        wait_q(3);
        `CHK("fault addr", 6'h10, u_flash.log_q[1].addr)
        `CHK("fault word", 32'h80520abc, u_flash.log_q[1].data)
        `CHK("time addr", 6'h11, u_flash.log_q[2].addr)
        `CHK("fault time", 1'b1, u_flash.log_q[2].data < 32'h20)
        send_fault(4'h7, 4'h4, 12'h123);
        wait_q(5);
        `CHK("second fault", 6'h12, u_flash.log_q[3].addr)
        host_read(6'h10, 32'h80520abc);
    endtask
    // brownout mode: nothing written until the supply drops
    task t_brown();
        do_reset(1'b1);
        // let the load cycle pass, it overrides a clock write
        tick();
        ack_wait = 4'h2;
        host_rtc_value = 32'h1000;
        host_rtc_wr = 1'b1;
        meas = '{rail: 4'h1, volt: 12'h0ff};
        meas_valid = 1'b1;
        tick();
        host_rtc_wr = 1'b0;
        meas_valid = 1'b0;
        tick();
        for (n = 0; n < 40 && window_active === 1'b1; n++) tick();
        repeat (4) tick();
        `CHK("no normal writes", 0, u_flash.log_q.size())
        vcc_below_2v9 = 1'b1;
        wait_done();
        `CHK("copied words", 65, u_flash.log_q.size())
        `CHK("host blocked", 1'b0, host_rd_ready)
        `CHK("clock first", 6'h31, u_flash.log_q[0].addr)
        `CHK("host clock", 1'b1, u_flash.log_q[0].data >= 32'h1000 &&
             u_flash.log_q[0].data < 32'h1040)
        `CHK("peak copy", 32'hff, u_flash.log_q[2].data)
        `CHK("count copy", 32'h6, u_flash.log_q[49].data)
        ack_wait = 4'h0;
    endtask
    // clock kept across reset in brownout mode, zeroed otherwise
    task t_rtc();
        do_reset(1'b1);
        vcc_below_2v9 = 1'b1;
        wait_done();
        `CHK("kept clock", 1'b1, u_flash.log_q[0].data >= 32'h500 &&
             u_flash.log_q[0].data < 32'h540)
        do_reset(1'b0);
        tick();
        bo_mode_en = 1'b1;
        repeat (10) tick();
        u_flash.log_q.delete();
        vcc_below_2v9 = 1'b1;
        wait_done();
        `CHK("zeroed clock", 1'b1, u_flash.log_q[0].data < 32'h40)
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        tick();
        t_count();
        t_peak();
        t_fault();
        t_brown();
        t_rtc();
        give_verdict();
    end
    // watchdog against a hang
    initial begin
        #300000;
        num_errors++;
        give_verdict();
    end
endmodule
